// ===== bench/msc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module msc_host_model (
	// clock
	input wire logic ref_clk,
	// step pins toward the device
	output logic step_rise_input,
	output logic step_any_edge_input
);
	initial begin
		step_rise_input = 1'b0;
		step_any_edge_input = 1'b0;
	end
	// one step on the chosen pin, the other keeps its level; hold sets the pace
	task automatic step(input logic use_any, input int hold);
		if (use_any) begin
			step_any_edge_input <= ~step_any_edge_input;
		end else begin
			step_rise_input <= 1'b1;
			repeat (hold) @(posedge ref_clk);
			#1 step_rise_input <= 1'b0;
		end
		repeat (hold) @(posedge ref_clk);
		#1;
	endtask : step
endmodule : msc_host_model
`default_nettype wire

// ===== bench/msc_sequencer_sva.sv
`timescale 1ns/100ps
`default_nettype none
module msc_sequencer_sva #(
	parameter logic [msc_pkg::OFF_CNT_W-1:0] OFF_LONG_CYCLES = msc_pkg::OFF_LONG_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// host pins
	input wire logic sleep_request,
	input wire logic reset_request_n,
	input wire logic off_time_select,
	input wire logic low_supply_lockout,
	input wire logic overheat_detect,
	// outputs
	input wire logic [msc_pkg::POS_W-1:0] seq_position,
	input wire logic bridge_on,
	input wire logic phase_a_drive,
	input wire logic phase_a_fast,
	input wire logic phase_a_slow,
	input wire logic overheat_latch,
	input wire logic overcurrent_latch,
	input wire logic fault_flag_out,
	input wire logic fault_flag_oe_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// ************************************************************
	// length of the running off period of phase a
	// ************************************************************
	logic [msc_pkg::OFF_CNT_W-1:0] off_cnt_q;
	logic [msc_pkg::OFF_CNT_W-1:0] off_cnt_d;
	always_comb begin
		off_cnt_d = msc_pkg::CNT_ZERO;
		if (phase_a_fast || phase_a_slow) begin
			off_cnt_d = off_cnt_q + msc_pkg::CNT_ONE;
		end
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			off_cnt_q <= msc_pkg::CNT_ZERO;
		end else begin
			off_cnt_q <= off_cnt_d;
		end
	end
	// ************************************************************
	// assertions
	// ************************************************************
	flag_follows_latch_a: assert property (
		fault_flag_oe_n == !(overheat_latch || overcurrent_latch) && !fault_flag_out)
		else $error("fault flag does not follow latches");
	drive_gated_a: assert property (
		!bridge_on |-> !(phase_a_drive || phase_a_fast || phase_a_slow))
		else $error("phase drive while bridge off");
	heat_kills_bridge_a: assert property (overheat_latch |-> !bridge_on)
		else $error("bridge on with overheat latched");
	overcur_kills_bridge_a: assert property (overcurrent_latch |-> !bridge_on)
		else $error("bridge on with overcurrent latched");
	heat_sets_latch_a: assert property ($past(overheat_detect, 3) |-> overheat_latch)
		else $error("overheat not latched");
	heat_clear_cause_a: assert property ($fell(overheat_latch) |->
		!$past(sleep_request, 3) || !$past(reset_request_n, 3) || $past(low_supply_lockout, 3))
		else $error("overheat latch cleared without cause");
	sleep_idles_a: assert property (!sleep_request [*4] |=>
		!bridge_on && seq_position == msc_pkg::POS_RESET)
		else $error("sleep did not idle sequencer");
	reset_idles_a: assert property (!reset_request_n [*4] |=>
		!bridge_on && seq_position == msc_pkg::POS_RESET)
		else $error("reset did not idle sequencer");
	lockout_off_a: assert property (low_supply_lockout [*4] |=> !bridge_on)
		else $error("bridge on during lockout");
	off_period_a: assert property ($rose(phase_a_drive) && off_cnt_q != 0 |->
		off_cnt_q == (off_time_select ? msc_pkg::OFF_SHORT_CYCLES : OFF_LONG_CYCLES))
		else $error("off period length wrong");
	cover property ($rose(overheat_latch));
	cover property ($rose(phase_a_fast));
	cover property ($rose(bridge_on));
endmodule : msc_sequencer_sva
bind msc_sequencer_top msc_sequencer_sva #(.OFF_LONG_CYCLES(OFF_LONG_CYCLES)) i_msc_sequencer_sva (.*);
`default_nettype wire

// ===== bench/tb_msc_sequencer_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
	begin \
		check_count++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("ERROR %s expected %0h seen %0h", what, exp, got); \
		end \
	end
module tb_msc_sequencer_top;
	logic ref_clk, rstn, sleep_request, enable, reset_request_n;
	logic excite_sel_a, excite_sel_b, excite_sel_c, rotation_sense;
	logic fast_ratio_sel_hi, fast_ratio_sel_lo, off_time_select, monitor_select;
	logic junction_monitor, low_supply_lockout, overheat_detect, overcurrent_detect;
	logic phase_a_trip, phase_b_trip, step_rise_input, step_any_edge_input;
	logic [msc_pkg::SP_W-1:0] phase_a_setpoint, phase_b_setpoint;
	logic [msc_pkg::POS_W-1:0] seq_position;
	logic bridge_on, phase_a_drive, phase_a_fast, phase_a_slow;
	logic phase_b_drive, phase_b_fast, phase_b_slow;
	logic overheat_latch, overcurrent_latch, fault_flag_out, fault_flag_oe_n;
	logic monitor_pin_out, monitor_pin_oe_n;
	int mismatches = 0;
	int check_count = 0;
	// step size per {c, b, a} select code on the 64-position grid
	logic [5:0] inc_tbl [8] = '{6'h10, 6'h08, 6'h08, 6'h04, 6'h02, 6'h01, 6'h02, 6'h01};
	// expected {drive, fast, slow} just after a trip
	logic [2:0] off_exp;
	msc_sequencer_top #(.OFF_LONG_CYCLES(13'h0028)) i_msc_sequencer_top (.*);
	msc_host_model i_msc_host_model (.*);
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic func_reset();
		reset_request_n = 1'b0;
		settle(5);
		reset_request_n = 1'b1;
		settle(4);
	endtask : func_reset
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	initial begin
		#100000;
		mismatches++;
		conclude();
	end
	initial begin
		{rstn, enable, rotation_sense, monitor_select, junction_monitor} = 5'h00;
		{excite_sel_a, excite_sel_b, excite_sel_c, off_time_select} = 4'h0;
		{fast_ratio_sel_hi, fast_ratio_sel_lo, phase_a_trip, phase_b_trip} = 4'h0;
		{low_supply_lockout, overheat_detect, overcurrent_detect} = 3'h0;
		{sleep_request, reset_request_n} = 2'h3;
		settle(2);
		rstn = 1'b1;
		settle(4);
		// ************************************************************
		// every mode, both step pins, both senses, bridges disabled
		// ************************************************************
		for (int m = 0; m < 8; m++) begin
			{excite_sel_c, excite_sel_b, excite_sel_a} = m[2:0];
			rotation_sense = 1'b0;
			func_reset();
			`CHK("start position", msc_pkg::POS_RESET, seq_position)
			i_msc_host_model.step(1'b0, 2);
			i_msc_host_model.step(1'b1, 2);
			i_msc_host_model.step(1'b1, 2);
			settle(4);
			`CHK("forward", 6'(3 * inc_tbl[m]), seq_position)
			rotation_sense = 1'b1;
			i_msc_host_model.step(1'b0, 6);
			settle(4);
			`CHK("reverse", 6'(2 * inc_tbl[m]), seq_position)
			`CHK("bridge held off", 1'b0, bridge_on)
		end
		$display("test modes done");
		{excite_sel_c, excite_sel_b, excite_sel_a, rotation_sense} = 4'hA;
		func_reset();
		`CHK("set-point a", 11'h2C3, phase_a_setpoint)
		`CHK("set-point b", 11'h53D, phase_b_setpoint)
		repeat (8) i_msc_host_model.step(1'b0, 2);
		settle(4);
		`CHK("zero deg", 22'h1F4000, {phase_a_setpoint, phase_b_setpoint})
		monitor_select = 1'b1;
		settle(4);
		`CHK("home off", 1'b1, monitor_pin_oe_n)
		func_reset();
		`CHK("home on", 1'b0, monitor_pin_oe_n)
		{monitor_select, junction_monitor} = 2'h1;
		settle(4);
		`CHK("junction relay", 2'h1, {monitor_pin_oe_n, monitor_pin_out})
		$display("test set-points done");
		enable = 1'b1;
		settle(4);
		`CHK("bridge on", 1'b1, bridge_on)
		for (int d = 0; d < 5; d++) begin
			{fast_ratio_sel_hi, fast_ratio_sel_lo} = (d == 4) ? 2'h3 : d[1:0];
			off_time_select = (d == 4);
			off_exp = (d == 0) ? 3'h1 : 3'h2;
			{phase_a_trip, phase_b_trip} = 2'h3;
			settle(2);
			{phase_a_trip, phase_b_trip} = 2'h0;
			settle(3);
			`CHK("off a", off_exp, {phase_a_drive, phase_a_fast, phase_a_slow})
			`CHK("off b", off_exp, {phase_b_drive, phase_b_fast, phase_b_slow})
			settle((d == 4) ? 3100 : 50);
			`CHK("drive back", 2'h3, {phase_a_drive, phase_b_drive})
		end
		$display("test decay done");
		overheat_detect = 1'b1;
		settle(4);
		overheat_detect = 1'b0;
		settle(4);
		`CHK("heat latched", 3'h4, {overheat_latch, bridge_on, fault_flag_oe_n})
		func_reset();
		`CHK("heat cleared", 3'h3, {overheat_latch, bridge_on, fault_flag_oe_n})
		overcurrent_detect = 1'b1;
		settle(4);
		overcurrent_detect = 1'b0;
		settle(4);
		`CHK("oc latched", 3'h4, {overcurrent_latch, bridge_on, fault_flag_oe_n})
		i_msc_host_model.step(1'b0, 2);
		low_supply_lockout = 1'b1;
		settle(4);
		`CHK("lockout", 8'h00, {overcurrent_latch, bridge_on, seq_position})
		low_supply_lockout = 1'b0;
		i_msc_host_model.step(1'b0, 2);
		settle(4);
		`CHK("stepped", 7'h41, {bridge_on, seq_position})
		sleep_request = 1'b0;
		settle(5);
		`CHK("sleep", 7'h00, {bridge_on, seq_position})
		sleep_request = 1'b1;
		settle(4);
		$display("test protection done");
		conclude();
	end
endmodule : tb_msc_sequencer_top
`default_nettype wire

// ===== logic/msc_phase_pwm.sv
`timescale 1ns/100ps
`default_nettype none
module msc_phase_pwm (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// control
	input wire logic bridge_on,
	input wire logic trip,
	input wire logic [msc_pkg::OFF_CNT_W-1:0] off_len,
	input wire logic [msc_pkg::OFF_CNT_W-1:0] fast_len,
	// bridge drive
	output logic drive_q,
	output logic fast_q,
	output logic slow_q
);

	// ************************************************************
	// off period sequencing
	// ************************************************************
	msc_pkg::msc_ph_state_t state_q, state_d;
	logic [msc_pkg::OFF_CNT_W-1:0] cnt_q, cnt_d;
	logic [msc_pkg::OFF_CNT_W-1:0] cnt_inc;
	logic drive_d, fast_d, slow_d;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		cnt_inc = cnt_q + msc_pkg::CNT_ONE;
		unique case (state_q)
			msc_pkg::MSC_PH_DRIVE: begin
				if (bridge_on && trip) begin
					cnt_d = msc_pkg::CNT_ZERO;
					state_d = (fast_len != msc_pkg::CNT_ZERO) ? msc_pkg::MSC_PH_FAST
						: msc_pkg::MSC_PH_SLOW;
				end
			end
			msc_pkg::MSC_PH_FAST, msc_pkg::MSC_PH_SLOW: begin
				if (cnt_inc >= off_len) begin
					state_d = msc_pkg::MSC_PH_DRIVE;
					cnt_d = msc_pkg::CNT_ZERO;
				end else begin
					cnt_d = cnt_inc;
					state_d = (cnt_inc >= fast_len) ? msc_pkg::MSC_PH_SLOW
						: state_q;
				end
			end
			default: begin
				state_d = msc_pkg::MSC_PH_DRIVE;
				cnt_d = msc_pkg::CNT_ZERO;
			end
		endcase
		if (!bridge_on) begin
			state_d = msc_pkg::MSC_PH_DRIVE;
			cnt_d = msc_pkg::CNT_ZERO;
		end
		drive_d = bridge_on && (state_d == msc_pkg::MSC_PH_DRIVE);
		fast_d = bridge_on && (state_d == msc_pkg::MSC_PH_FAST);
		slow_d = bridge_on && (state_d == msc_pkg::MSC_PH_SLOW);
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= msc_pkg::MSC_PH_DRIVE;
			cnt_q <= msc_pkg::CNT_ZERO;
			drive_q <= 1'b0;
			fast_q <= 1'b0;
			slow_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			drive_q <= drive_d;
			fast_q <= fast_d;
			slow_q <= slow_d;
		end
	end

endmodule : msc_phase_pwm
`default_nettype wire

// ===== logic/msc_pkg.sv
`default_nettype none
package msc_pkg;

	// ************************************************************
	// clock and pwm off timing
	// ************************************************************
	localparam int CLK_FREQ_MHZ = 200;
	localparam int OFF_TIME_LONG_NS = 28000;
	localparam int OFF_TIME_SHORT_NS = 15200;
	localparam int OFF_CNT_W = 13;
	localparam int OFF_LONG_CYC_INT = (OFF_TIME_LONG_NS * CLK_FREQ_MHZ) / 1000;
	localparam int OFF_SHORT_CYC_INT = (OFF_TIME_SHORT_NS * CLK_FREQ_MHZ) / 1000;
	localparam logic [OFF_CNT_W-1:0] OFF_LONG_CYCLES = OFF_CNT_W'(OFF_LONG_CYC_INT);
	localparam logic [OFF_CNT_W-1:0] OFF_SHORT_CYCLES = OFF_CNT_W'(OFF_SHORT_CYC_INT);

	// ************************************************************
	// sequencer position and set-points
	// ************************************************************
	localparam int POS_W = 6;
	localparam logic [POS_W-1:0] POS_RESET = 6'h00;
	localparam logic [POS_W-1:0] POS_ZERO_DEG = 6'h08;
	localparam logic [POS_W-1:0] POS_QUARTER = 6'h10;
	localparam logic [3:0] HOME_MASK_ZERO = 4'h0;
	localparam int SP_W = 11;
	localparam logic [SP_W-1:0] SP_ZERO = 11'h000;
	localparam logic [OFF_CNT_W-1:0] CNT_ZERO = 13'h0000;
	localparam logic [OFF_CNT_W-1:0] CNT_ONE = 13'h0001;

	// excitation modes, one step of each in units of the 64-position grid
	typedef enum logic [2:0] {
		MSC_MODE_FULL4 = 3'h0,
		MSC_MODE_HALF8 = 3'h1,
		MSC_MODE_ONETWO8 = 3'h2,
		MSC_MODE_W16 = 3'h3,
		MSC_MODE_W32 = 3'h4,
		MSC_MODE_W64 = 3'h5
	} msc_mode_t;

	localparam logic [POS_W-1:0] INC_FULL4 = 6'h10;
	localparam logic [POS_W-1:0] INC_EIGHT = 6'h08;
	localparam logic [POS_W-1:0] INC_W16 = 6'h04;
	localparam logic [POS_W-1:0] INC_W32 = 6'h02;
	localparam logic [POS_W-1:0] INC_W64 = 6'h01;

	// fast decay share of the off period, {hi select, lo select}
	localparam logic [1:0] DECAY_SLOW = 2'h0;
	localparam logic [1:0] DECAY_QUARTER = 2'h1;
	localparam logic [1:0] DECAY_HALF = 2'h2;
	localparam logic [1:0] DECAY_FULL = 2'h3;

	// per-phase pwm states
	typedef enum logic [1:0] {
		MSC_PH_DRIVE = 2'h0,
		MSC_PH_FAST = 2'h1,
		MSC_PH_SLOW = 2'h2
	} msc_ph_state_t;

endpackage : msc_pkg
`default_nettype wire

// ===== logic/msc_sequencer_top.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - all selects low full, second high half
// - first high: 8 or 16 by second
// - third high: 32 or 64, second ignored
// - rotation sense picks phase B lag or lead
// - sleep resets sequencer, bridges off always
// - reset low holds sequencer, bridges off
// - enable low: sequencer runs, bridges off
// - bridges on only when all three high
// - decay selects set fast share of off
// - off period 28.0 or 15.2 us
// - overheat latches bridges off until cleared
// - overcurrent latches bridges off until cleared
// - low supply lockout forces bridges off
// - fault flag pulled low while latched
// - monitor pin: junction or home indication
// - rising edges step the rise input
// - both edges step the any-edge input
// - restart at minus 45 degrees, entry one
// - direction change keeps current position
// - steps while disabled still advance position
module msc_sequencer_top #(
	parameter logic [msc_pkg::OFF_CNT_W-1:0] OFF_LONG_CYCLES = msc_pkg::OFF_LONG_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// host control pins
	input wire logic sleep_request,
	input wire logic enable,
	input wire logic reset_request_n,
	input wire logic excite_sel_a,
	input wire logic excite_sel_b,
	input wire logic excite_sel_c,
	input wire logic rotation_sense,
	input wire logic step_rise_input,
	input wire logic step_any_edge_input,
	input wire logic fast_ratio_sel_hi,
	input wire logic fast_ratio_sel_lo,
	input wire logic off_time_select,
	input wire logic monitor_select,
	// analog status
	input wire logic junction_monitor,
	input wire logic low_supply_lockout,
	input wire logic overheat_detect,
	input wire logic overcurrent_detect,
	input wire logic phase_a_trip,
	input wire logic phase_b_trip,
	// set-points and position
	output logic [msc_pkg::SP_W-1:0] phase_a_setpoint,
	output logic [msc_pkg::SP_W-1:0] phase_b_setpoint,
	output logic [msc_pkg::POS_W-1:0] seq_position,
	// bridge drive
	output logic bridge_on,
	output logic phase_a_drive,
	output logic phase_a_fast,
	output logic phase_a_slow,
	output logic phase_b_drive,
	output logic phase_b_fast,
	output logic phase_b_slow,
	// status
	output logic overheat_latch,
	output logic overcurrent_latch,
	// open-drain and monitor pins
	output logic fault_flag_out,
	output logic fault_flag_oe_n,
	output logic monitor_pin_out,
	output logic monitor_pin_oe_n
);

	// ************************************************************
	// input synchronisers
	// ************************************************************
	localparam int NSYNC = 19;
	logic [NSYNC-1:0] sync1_q, sync2_q, sync_raw;
	logic s_sleep, s_enable, s_reset_n, s_sel_a, s_sel_b, s_sel_c, s_dir;
	logic s_step_rise, s_step_any, s_dec_hi, s_dec_lo, s_off_sel, s_mon_sel;
	logic s_junction, s_lockout, s_overheat, s_overcur, s_trip_a, s_trip_b;

	assign sync_raw = {sleep_request, enable, reset_request_n, excite_sel_a, excite_sel_b,
		excite_sel_c, rotation_sense, step_rise_input, step_any_edge_input,
		fast_ratio_sel_hi, fast_ratio_sel_lo, off_time_select, monitor_select,
		junction_monitor, low_supply_lockout, overheat_detect, overcurrent_detect,
		phase_a_trip, phase_b_trip};
	assign {s_sleep, s_enable, s_reset_n, s_sel_a, s_sel_b, s_sel_c, s_dir,
		s_step_rise, s_step_any, s_dec_hi, s_dec_lo, s_off_sel, s_mon_sel,
		s_junction, s_lockout, s_overheat, s_overcur, s_trip_a, s_trip_b} = sync2_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= sync_raw;
			sync2_q <= sync1_q;
		end
	end

	// ************************************************************
	// mode decode and set-point lookup
	// ************************************************************
	function automatic msc_pkg::msc_mode_t decode_mode(input logic a, input logic b,
		input logic c);
		msc_pkg::msc_mode_t m;
		if (c) begin
			m = a ? msc_pkg::MSC_MODE_W64 : msc_pkg::MSC_MODE_W32;
		end else if (a) begin
			m = b ? msc_pkg::MSC_MODE_W16 : msc_pkg::MSC_MODE_ONETWO8;
		end else begin
			m = b ? msc_pkg::MSC_MODE_HALF8 : msc_pkg::MSC_MODE_FULL4;
		end
		return m;
	endfunction : decode_mode

	function automatic logic [msc_pkg::POS_W-1:0] mode_inc(input msc_pkg::msc_mode_t m);
		logic [msc_pkg::POS_W-1:0] inc;
		unique case (m)
			msc_pkg::MSC_MODE_FULL4: inc = msc_pkg::INC_FULL4;
			msc_pkg::MSC_MODE_HALF8: inc = msc_pkg::INC_EIGHT;
			msc_pkg::MSC_MODE_ONETWO8: inc = msc_pkg::INC_EIGHT;
			msc_pkg::MSC_MODE_W16: inc = msc_pkg::INC_W16;
			msc_pkg::MSC_MODE_W32: inc = msc_pkg::INC_W32;
			msc_pkg::MSC_MODE_W64: inc = msc_pkg::INC_W64;
			default: inc = msc_pkg::INC_W64;
		endcase
		return inc;
	endfunction : mode_inc

	// cosine of m * 5.625 degrees in tenths of a percent
	function automatic logic [msc_pkg::SP_W-1:0] cos_mag(input logic [4:0] m);
		logic [msc_pkg::SP_W-1:0] v;
		unique case (m)
			5'h00: v = 11'h3E8;
			5'h01: v = 11'h3E3;
			5'h02: v = 11'h3D5;
			5'h03: v = 11'h3BD;
			5'h04: v = 11'h39C;
			5'h05: v = 11'h372;
			5'h06: v = 11'h33F;
			5'h07: v = 11'h305;
			5'h08: v = 11'h2C3;
			5'h09: v = 11'h27A;
			5'h0A: v = 11'h22C;
			5'h0B: v = 11'h1D7;
			5'h0C: v = 11'h17F;
			5'h0D: v = 11'h122;
			5'h0E: v = 11'h0C3;
			5'h0F: v = 11'h062;
			default: v = 11'h000;
		endcase
		return v;
	endfunction : cos_mag

	// signed cosine over a 64-position electrical turn
	function automatic logic [msc_pkg::SP_W-1:0] cos64(input logic [msc_pkg::POS_W-1:0] j);
		logic [4:0] m, mr;
		logic [msc_pkg::SP_W-1:0] v;
		m = {1'b0, j[3:0]};
		mr = 5'h10 - m;
		unique case (j[5:4])
			2'h0: v = cos_mag(m);
			2'h1: v = msc_pkg::SP_ZERO - cos_mag(mr);
			2'h2: v = msc_pkg::SP_ZERO - cos_mag(m);
			default: v = cos_mag(mr);
		endcase
		return v;
	endfunction : cos64

	// ************************************************************
	// sequencer, protection and pin control
	// ************************************************************
	logic rise_prev_q, rise_prev_d, any_prev_q, any_prev_d;
	logic [msc_pkg::POS_W-1:0] pos_q, pos_d, ang;
	logic oh_q, oh_d, oc_q, oc_d;
	logic bridge_q, bridge_d;
	logic [msc_pkg::SP_W-1:0] sp_a_q, sp_a_d, sp_b_q, sp_b_d;
	logic fault_oe_n_q, fault_oe_n_d, mon_out_q, mon_out_d, mon_oe_n_q, mon_oe_n_d;
	logic logic_rst, step_evt, latch_clr, home;
	msc_pkg::msc_mode_t mode;

	always_comb begin
		rise_prev_d = s_step_rise;
		any_prev_d = s_step_any;
		mode = decode_mode(s_sel_a, s_sel_b, s_sel_c);
		logic_rst = !s_sleep || !s_reset_n;
		// a single event even if both inputs move together
		step_evt = (s_step_rise && !rise_prev_q)
			|| (s_step_any != any_prev_q);
		pos_d = pos_q;
		if (logic_rst || s_lockout) begin
			pos_d = msc_pkg::POS_RESET;
		end else if (step_evt) begin
			// only the sense of the step changes, position is kept
			pos_d = s_dir ? (pos_q - mode_inc(mode)) : (pos_q + mode_inc(mode));
		end
		latch_clr = logic_rst || s_lockout;
		oh_d = s_overheat || (oh_q && !latch_clr);
		oc_d = s_overcur || (oc_q && !latch_clr);
		bridge_d = s_sleep && s_enable && s_reset_n
			&& !s_lockout && !oh_d && !oc_d;
		ang = pos_d - msc_pkg::POS_ZERO_DEG;
		sp_a_d = cos64(ang);
		sp_b_d = cos64(ang - msc_pkg::POS_QUARTER);
		fault_oe_n_d = !(oh_d || oc_d);
		home = (pos_d[3:0] == msc_pkg::HOME_MASK_ZERO);
		mon_out_d = s_mon_sel ? 1'b0 : s_junction;
		mon_oe_n_d = s_mon_sel ? !home : 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rise_prev_q <= 1'b0;
			any_prev_q <= 1'b0;
			pos_q <= msc_pkg::POS_RESET;
			oh_q <= 1'b0;
			oc_q <= 1'b0;
			bridge_q <= 1'b0;
			sp_a_q <= msc_pkg::SP_ZERO;
			sp_b_q <= msc_pkg::SP_ZERO;
			fault_oe_n_q <= 1'b1;
			mon_out_q <= 1'b0;
			mon_oe_n_q <= 1'b1;
		end else begin
			rise_prev_q <= rise_prev_d;
			any_prev_q <= any_prev_d;
			pos_q <= pos_d;
			oh_q <= oh_d;
			oc_q <= oc_d;
			bridge_q <= bridge_d;
			sp_a_q <= sp_a_d;
			sp_b_q <= sp_b_d;
			fault_oe_n_q <= fault_oe_n_d;
			mon_out_q <= mon_out_d;
			mon_oe_n_q <= mon_oe_n_d;
		end
	end

	// ************************************************************
	// pwm off timing per phase
	// ************************************************************
	logic [msc_pkg::OFF_CNT_W-1:0] off_len, fast_len;

	always_comb begin
		off_len = s_off_sel ? msc_pkg::OFF_SHORT_CYCLES : OFF_LONG_CYCLES;
		unique case ({s_dec_hi, s_dec_lo})
			msc_pkg::DECAY_SLOW: fast_len = msc_pkg::CNT_ZERO;
			msc_pkg::DECAY_QUARTER: fast_len = off_len >> 2;
			msc_pkg::DECAY_HALF: fast_len = off_len >> 1;
			default: fast_len = off_len;
		endcase
	end

	// drives take the next bridge state so they drop on the same edge as bridge_on
	msc_phase_pwm u_pwm_a (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.bridge_on(bridge_d),
		.trip(s_trip_a),
		.off_len(off_len),
		.fast_len(fast_len),
		.drive_q(phase_a_drive),
		.fast_q(phase_a_fast),
		.slow_q(phase_a_slow)
	);

	msc_phase_pwm u_pwm_b (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.bridge_on(bridge_d),
		.trip(s_trip_b),
		.off_len(off_len),
		.fast_len(fast_len),
		.drive_q(phase_b_drive),
		.fast_q(phase_b_fast),
		.slow_q(phase_b_slow)
	);

	// ************************************************************
	// outputs
	// ************************************************************
	assign phase_a_setpoint = sp_a_q;
	assign phase_b_setpoint = sp_b_q;
	assign seq_position = pos_q;
	assign bridge_on = bridge_q;
	assign overheat_latch = oh_q;
	assign overcurrent_latch = oc_q;
	// open-drain: the pin only ever pulls low
	assign fault_flag_out = 1'b0;
	assign fault_flag_oe_n = fault_oe_n_q;
	assign monitor_pin_out = mon_out_q;
	assign monitor_pin_oe_n = mon_oe_n_q;

endmodule : msc_sequencer_top
`default_nettype wire
